// ===== rtl/tde_tap_engine.sv
// Purpose: Single and double tap detector driven by the accel sample strobe.
// Assumes: Register bytes and samples come from logic on sys_clk.
// Notes: Result, status and interrupt pins are all registered.
// Functional notes
// - Tap axis: largest axis at the crossing sample; priority breaks ties
// - Peak valid if quiet at peak window end
// - Stay quiet through tap window after tap
// - Second tap between tap and double windows
// - Double window counts from first peak sample
// - Acceleration average weight, seven fraction bits
// - Magnitude average weight, seven fraction bits
// - Peak threshold sixteen bits, ten fraction bits
// - Quiet threshold sixteen bits, ten fraction bits
// - Command 0x0C commits the staged parameter set
// - Set one: peak, priority, tap, double windows
// - Set two: weights, peak and quiet thresholds
// - Runs only with tap enable and accel on
// - Route event to pin a or b, gated
// - Report sets tap bit in status register
// - Tap result updated on each reported tap
// - Count field: one single, two double
// - Axis field: 1 X, 2 Y, 3 Z
// - Polarity from sign at first valid peak
// - Linear value is sample minus its average
// - Peak starts when energy reaches threshold
// - Tap inside tap window restarts, no report
// - Double window timeout reports a single tap
`timescale 1ns/1ps
module tde_tap_engine (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Staged parameter bytes
  input wire logic [tde_pkg::BYTE_W-1:0] param_byte1_low,
  input wire logic [tde_pkg::BYTE_W-1:0] param_byte1_high,
  input wire logic [tde_pkg::BYTE_W-1:0] param_byte2_low,
  input wire logic [tde_pkg::BYTE_W-1:0] param_byte2_high,
  input wire logic [tde_pkg::BYTE_W-1:0] param_byte3_low,
  input wire logic [tde_pkg::BYTE_W-1:0] param_byte3_high,
  input wire logic [tde_pkg::BYTE_W-1:0] param_set_selector,
  // Command register write
  input wire logic cmd_wr,
  input wire logic [tde_pkg::BYTE_W-1:0] command_register,
  // Control registers
  input wire logic [tde_pkg::BYTE_W-1:0] engine_enable_reg,
  input wire logic [tde_pkg::BYTE_W-1:0] sensor_enable_reg,
  input wire logic [tde_pkg::BYTE_W-1:0] pin_config_reg,
  // Status read strobe, clears the status register
  input wire logic event_status_rd,
  // Accelerometer samples
  input wire logic sample_ready,
  input wire logic signed [tde_pkg::SAMPLE_W-1:0] accel_x,
  input wire logic signed [tde_pkg::SAMPLE_W-1:0] accel_y,
  input wire logic signed [tde_pkg::SAMPLE_W-1:0] accel_z,
  // Results
  output logic [tde_pkg::BYTE_W-1:0] tap_result,
  output logic [tde_pkg::BYTE_W-1:0] event_status_reg,
  output logic irq_pin_a,
  output logic irq_pin_b
);
  import tde_pkg::*;

  // Pick the tap axis: largest magnitude wins, priority order breaks ties
  function automatic logic [1:0] pick_axis(input logic [SAMPLE_W:0] mx,
                                           input logic [SAMPLE_W:0] my,
                                           input logic [SAMPLE_W:0] mz,
                                           input logic [2:0] p);
    logic [5:0] ord;
    logic [SAMPLE_W:0] top;
    logic [SAMPLE_W:0] m;
    logic [1:0] code;
    logic [1:0] res;
    case (p)
      3'h1: ord = {AX_X, AX_Z, AX_Y};
      3'h2: ord = {AX_Y, AX_X, AX_Z};
      3'h3: ord = {AX_Y, AX_Z, AX_X};
      3'h4: ord = {AX_Z, AX_X, AX_Y};
      3'h5: ord = {AX_Z, AX_Y, AX_X};
      default: ord = {AX_X, AX_Y, AX_Z};
    endcase
    top = (mx > my) ? mx : my;
    top = (mz > top) ? mz : top;
    res = ord[5:4];
    // Lowest priority first, so the highest tied axis writes last
    for (int k = 0; k < 3; k++)
    begin
      code = ord[2*k +: 2];
      m = (code == AX_X) ? mx : ((code == AX_Y) ? my : mz);
      if (m == top)
        res = code;
    end
    return res;
  endfunction

  // Parameter registers loaded by the commit command
  logic [7:0] peak_duration_limit;
  logic [2:0] prio;
  logic [15:0] post_tap_quiet_span;
  logic [15:0] second_tap_timeout;
  logic [7:0] alpha;
  logic [7:0] gamma;
  logic [15:0] peak_energy_threshold;
  logic [15:0] quiet_threshold;

  // Detection state
  tde_state_t state;
  tde_state_t next_state;
  logic [7:0] pk_cnt;
  logic [7:0] next_pk;
  logic [15:0] dt_cnt;
  logic [15:0] next_dt;
  logic [15:0] q_cnt;
  logic [15:0] next_q;
  logic [1:0] cap_axis;
  logic cap_neg;
  logic rep_single;
  logic rep_double;
  logic [7:0] next_result;

  // Signal path
  logic signed [SAMPLE_W-1:0] acc [3];
  logic signed [SAMPLE_W-1:0] avg [3];
  logic signed [SAMPLE_W:0] lin [3];
  logic [SAMPLE_W:0] mag [3];
  logic [2*SAMPLE_W+1:0] sq [3];
  logic [2*SAMPLE_W+3:0] energy_full;
  logic [ENERGY_W-1:0] energy;
  logic signed [ENERGY_W:0] mag_avg;
  logic over;
  logic quiet;
  logic run;
  logic step;
  logic start1;
  logic [1:0] first_axis;
  logic first_neg;
  logic cmd_tap;
  logic load1;
  logic load2;
  logic rep;

  // Command decode; the host stages bytes with sensors off beforehand
  assign cmd_tap = cmd_wr && (command_register == CMD_CFG_TAP);
  assign load1 = cmd_tap && (param_set_selector[SEL_LSB +: 4] == SEL_SET1);
  assign load2 = cmd_tap && (param_set_selector[SEL_LSB +: 4] == SEL_SET2);

  // Parameter load; a selector other than 1 or 2 is ignored
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      peak_duration_limit <= RST_PEAK_WIN;
      prio <= RST_PRIO;
      post_tap_quiet_span <= RST_TAP_WIN;
      second_tap_timeout <= RST_DTAP_WIN;
      alpha <= RST_ALPHA;
      gamma <= RST_GAMMA;
      peak_energy_threshold <= RST_PEAK_THR;
      quiet_threshold <= RST_QUIET_THR;
    end
    else if (load1)
    begin
      peak_duration_limit <= param_byte1_low;
      prio <= param_byte1_high[2:0];
      post_tap_quiet_span <= {param_byte2_high, param_byte2_low};
      second_tap_timeout <= {param_byte3_high, param_byte3_low};
    end
    else if (load2)
    begin
      alpha <= param_byte1_low;
      gamma <= param_byte1_high;
      peak_energy_threshold <= {param_byte2_high, param_byte2_low};
      quiet_threshold <= {param_byte3_high, param_byte3_low};
    end
  end

  // Enable gating and per-sample step
  assign run = engine_enable_reg[TAP_EN_BIT] && sensor_enable_reg[ACCEL_ON_BIT];
  assign step = run && sample_ready;
  assign acc[0] = accel_x;
  assign acc[1] = accel_y;
  assign acc[2] = accel_z;

  // Per-axis average, linear value, magnitude and square
  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_axis
      tde_ewma #(.W(SAMPLE_W)) u_avg (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .upd(sample_ready),
        .weight(alpha),
        .sample(acc[i]),
        .avg(avg[i])
      );
      assign lin[i] = {acc[i][SAMPLE_W-1], acc[i]} - {avg[i][SAMPLE_W-1], avg[i]};
      assign mag[i] = lin[i][SAMPLE_W] ? unsigned'(-lin[i]) : unsigned'(lin[i]);
      assign sq[i] = mag[i] * mag[i];
    end
  endgenerate

  // Energy in g squared with ten fraction bits
  assign energy_full = {2'b00, sq[0]} + {2'b00, sq[1]} + {2'b00, sq[2]};
  assign energy = energy_full[2*SAMPLE_W+3 -: ENERGY_W];
  assign over = energy >= ENERGY_W'(peak_energy_threshold);

  // Movement magnitude average; it lags, so short spikes decay over samples
  tde_ewma #(.W(ENERGY_W + 1)) u_mag (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .upd(sample_ready),
    .weight(gamma),
    .sample(signed'({1'b0, energy})),
    .avg(mag_avg)
  );
  assign quiet = !mag_avg[ENERGY_W] && (mag_avg[ENERGY_W-1:0] < ENERGY_W'(quiet_threshold));

  // Axis and sign at the crossing sample
  assign first_axis = pick_axis(mag[0], mag[1], mag[2], prio);
  assign first_neg = (first_axis == AX_X) ? lin[0][SAMPLE_W] :
                     ((first_axis == AX_Y) ? lin[1][SAMPLE_W] : lin[2][SAMPLE_W]);
  assign start1 = step && (state == S_IDLE) && over;

  // Detection sequence; counters only move on a sample strobe
  always_comb
  begin
    next_state = state;
    next_pk = pk_cnt;
    next_dt = dt_cnt;
    next_q = q_cnt;
    rep_single = 1'b0;
    rep_double = 1'b0;
    if (!run)
      next_state = S_IDLE;
    else if (sample_ready)
    begin
      next_pk = pk_cnt + 8'h01;
      next_dt = dt_cnt + 16'h0001;
      next_q = q_cnt + 16'h0001;
      case (state)
        S_IDLE:
        begin
          if (over)
          begin
            next_state = S_PEAK1;
            next_pk = 8'h01;
            next_dt = 16'h0001;
          end
        end
        S_PEAK1:
        begin
          if (pk_cnt >= peak_duration_limit)
          begin
            next_state = quiet ? S_QUIET : S_IDLE;
            next_q = 16'h0000;
          end
        end
        S_QUIET:
        begin
          if (over || !quiet)
            next_state = S_IDLE;
          else if (next_q >= post_tap_quiet_span)
            next_state = S_WAIT2;
        end
        S_WAIT2:
        begin
          if (dt_cnt >= second_tap_timeout)
          begin
            rep_single = 1'b1;
            next_state = S_IDLE;
          end
          else if (over)
          begin
            next_state = S_PEAK2;
            next_pk = 8'h01;
          end
        end
        S_PEAK2:
        begin
          if (dt_cnt >= second_tap_timeout)
          begin
            rep_single = 1'b1;
            next_state = S_IDLE;
          end
          else if (pk_cnt >= peak_duration_limit)
          begin
            rep_double = quiet;
            next_state = S_IDLE;
          end
        end
        default: next_state = S_IDLE;
      endcase
    end
  end

  // State and counters
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state <= S_IDLE;
      pk_cnt <= 8'h00;
      dt_cnt <= 16'h0000;
      q_cnt <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      pk_cnt <= next_pk;
      dt_cnt <= next_dt;
      q_cnt <= next_q;
    end
  end

  // Capture axis and sign of the first peak of a round
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cap_axis <= AX_X;
      cap_neg <= 1'b0;
    end
    else if (start1)
    begin
      cap_axis <= first_axis;
      cap_neg <= first_neg;
    end
  end

  // Result word assembly
  assign rep = rep_single || rep_double;
  always_comb
  begin
    next_result = tap_result;
    if (rep)
    begin
      next_result = 8'h00;
      next_result[RES_CNT_LSB +: 2] = rep_double ? COUNT_DOUBLE : COUNT_SINGLE;
      next_result[RES_AXIS_LSB +: 2] = cap_axis;
      next_result[RES_POL_BIT] = cap_neg;
    end
  end

  // Outputs; a report wins over a status read in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      tap_result <= 8'h00;
      event_status_reg <= 8'h00;
      irq_pin_a <= 1'b0;
      irq_pin_b <= 1'b0;
    end
    else
    begin
      tap_result <= next_result;
      if (rep)
        event_status_reg[STATUS_TAP_BIT] <= 1'b1;
      else if (event_status_rd)
        event_status_reg[STATUS_TAP_BIT] <= 1'b0;
      // Pins hold the event for one sample period, cleared by the next strobe
      if (rep)
      begin
        irq_pin_a <= engine_enable_reg[ROUTE_BIT] && pin_config_reg[PIN_A_EN_BIT];
        irq_pin_b <= !engine_enable_reg[ROUTE_BIT] && pin_config_reg[PIN_B_EN_BIT];
      end
      else if (sample_ready)
      begin
        irq_pin_a <= 1'b0;
        irq_pin_b <= 1'b0;
      end
    end
  end

  // Checks next to the logic they guard
  single_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rep_single |=> tap_result[RES_CNT_LSB +: 2] == COUNT_SINGLE
      && tap_result[RES_POL_BIT] == $past(cap_neg))
    else $error("single tap count wrong");
  double_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rep_double |=> tap_result[RES_CNT_LSB +: 2] == COUNT_DOUBLE
      && tap_result[RES_AXIS_LSB +: 2] == $past(cap_axis))
    else $error("double tap result wrong");
  status_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rep |=> event_status_reg[STATUS_TAP_BIT] ##1 event_status_reg[STATUS_TAP_BIT]
      || $past(event_status_rd))
    else $error("tap status bit not set");
  irq_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rep |=> irq_pin_a == $past(engine_enable_reg[ROUTE_BIT] && pin_config_reg[PIN_A_EN_BIT])
      && irq_pin_b == $past(!engine_enable_reg[ROUTE_BIT] && pin_config_reg[PIN_B_EN_BIT]))
    else $error("tap interrupt misrouted");
  stop_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !run |=> state == S_IDLE && !rep_single && !rep_double)
    else $error("engine ran while disabled");
  load_set1_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    load1 |=> peak_duration_limit == $past(param_byte1_low)
      && second_tap_timeout == {$past(param_byte3_high), $past(param_byte3_low)})
    else $error("first set not loaded");
  load_set2_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    load2 |=> peak_energy_threshold == {$past(param_byte2_high), $past(param_byte2_low)}
      && gamma == $past(param_byte1_high))
    else $error("second set not loaded");
  peak_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    start1 |=> state == S_PEAK1 && pk_cnt == 8'h01 && dt_cnt == 16'h0001)
    else $error("peak not started");
  quiet_break_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == S_QUIET && step && over) |-> !rep ##1 state == S_IDLE)
    else $error("tap in quiet span not discarded");

endmodule

// ===== common/tde_pkg.sv
// Purpose: Shared constants and types for the tap detection engine.
// Assumes: Samples are signed with ten fraction bits per g.
// Notes: Parameter reset values equal typical settings at a 500 Hz rate.
package tde_pkg;

  // Data widths
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned ENERGY_SHIFT = 10;
  localparam int unsigned ENERGY_W = 2 * SAMPLE_W + 4 - ENERGY_SHIFT;
  localparam int unsigned WEIGHT_FRAC = 7;

  // Command decode and parameter set selection
  localparam logic [7:0] CMD_CFG_TAP = 8'h0C;
  localparam logic [3:0] SEL_SET1 = 4'h1;
  localparam logic [3:0] SEL_SET2 = 4'h2;
  localparam int unsigned SEL_LSB = 4;

  // Register address of the tap result, for the host-side map
  localparam logic [7:0] TAP_RESULT_ADDR = 8'h59;

  // Control and status bit positions
  localparam int unsigned TAP_EN_BIT = 0;
  localparam int unsigned ROUTE_BIT = 6;
  localparam int unsigned ACCEL_ON_BIT = 0;
  localparam int unsigned PIN_A_EN_BIT = 3;
  localparam int unsigned PIN_B_EN_BIT = 4;
  localparam int unsigned STATUS_TAP_BIT = 1;

  // Tap result layout
  localparam int unsigned RES_CNT_LSB = 0;
  localparam int unsigned RES_AXIS_LSB = 4;
  localparam int unsigned RES_POL_BIT = 7;
  localparam logic [1:0] COUNT_SINGLE = 2'h1;
  localparam logic [1:0] COUNT_DOUBLE = 2'h2;
  localparam logic [1:0] AX_X = 2'h1;
  localparam logic [1:0] AX_Y = 2'h2;
  localparam logic [1:0] AX_Z = 2'h3;

  // Parameter reset values
  localparam logic [7:0] RST_PEAK_WIN = 8'h14;
  localparam logic [2:0] RST_PRIO = 3'h0;
  localparam logic [15:0] RST_TAP_WIN = 16'h0032;
  localparam logic [15:0] RST_DTAP_WIN = 16'h00FA;
  localparam logic [7:0] RST_ALPHA = 8'h08;
  localparam logic [7:0] RST_GAMMA = 8'h20;
  localparam logic [15:0] RST_PEAK_THR = 16'h0320;
  localparam logic [15:0] RST_QUIET_THR = 16'h0190;

  // Detection states, Gray coded along the usual path
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_PEAK1 = 3'b001,
    S_QUIET = 3'b011,
    S_WAIT2 = 3'b010,
    S_PEAK2 = 3'b110
  } tde_state_t;

endpackage

// ===== rtl/tde_ewma.sv
// Purpose: Running weighted average, one step per update strobe.
// Assumes: Weight is unsigned with seven fraction bits.
// Notes: Weights above 1.0 overshoot; the sum wraps rather than saturates.
`timescale 1ns/1ps
module tde_ewma #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Update strobe and weight
  input wire logic upd,
  input wire logic [tde_pkg::BYTE_W-1:0] weight,
  // Data in and average out
  input wire logic signed [W-1:0] sample,
  output logic signed [W-1:0] avg
);
  import tde_pkg::*;

  logic signed [W:0] diff;
  logic signed [W+9:0] prod;
  logic signed [W+9:0] step;
  logic signed [W+9:0] next_avg_wide;

  // Step toward the new value by weight times the difference
  assign diff = {sample[W-1], sample} - {avg[W-1], avg};
  assign prod = diff * $signed({1'b0, weight});
  assign step = prod >>> WEIGHT_FRAC;
  assign next_avg_wide = step + {{10{avg[W-1]}}, avg};

  // Average register, moved only on a sample strobe
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      avg <= '0;
    else if (upd)
      avg <= next_avg_wide[W-1:0];
  end

endmodule

// ===== dv/tde_host_model.sv
// Purpose: Host-side model that stages tap parameters and drives control bytes.
// Assumes: Every change lands 1 ns after a rising edge of sys_clk.
// Notes: Sensors are switched off before every commit, as a careful host would.
`timescale 1ns/1ps
module tde_host_model (
  // Clock
  input wire logic sys_clk,
  // Staged parameter bytes
  output logic [tde_pkg::BYTE_W-1:0] param_byte1_low,
  output logic [tde_pkg::BYTE_W-1:0] param_byte1_high,
  output logic [tde_pkg::BYTE_W-1:0] param_byte2_low,
  output logic [tde_pkg::BYTE_W-1:0] param_byte2_high,
  output logic [tde_pkg::BYTE_W-1:0] param_byte3_low,
  output logic [tde_pkg::BYTE_W-1:0] param_byte3_high,
  output logic [tde_pkg::BYTE_W-1:0] param_set_selector,
  // Command write
  output logic cmd_wr,
  output logic [tde_pkg::BYTE_W-1:0] command_register,
  // Control bytes and status read
  output logic [tde_pkg::BYTE_W-1:0] engine_enable_reg,
  output logic [tde_pkg::BYTE_W-1:0] sensor_enable_reg,
  output logic [tde_pkg::BYTE_W-1:0] pin_config_reg,
  output logic event_status_rd
);
  import tde_pkg::*;

  // Idle with sensors off until the bench asks for something
  initial
  begin
    {param_byte3_high, param_byte3_low, param_byte2_high, param_byte2_low} = '0;
    {param_byte1_high, param_byte1_low, param_set_selector} = '0;
    {engine_enable_reg, sensor_enable_reg, pin_config_reg} = '0;
    cmd_wr = 1'b0;
    command_register = 8'h00;
    event_status_rd = 1'b0;
  end

  // One commit: stage the six bytes and the selector in the same cycle as a single command strobe
  task automatic commit(input logic [3:0] set_id, input logic [47:0] bytes);
    @(posedge sys_clk);
    #1;
    sensor_enable_reg = 8'h00;
    {param_byte3_high, param_byte3_low, param_byte2_high} = bytes[47:24];
    {param_byte2_low, param_byte1_high, param_byte1_low} = bytes[23:0];
    param_set_selector = {set_id, 4'h0};
    command_register = CMD_CFG_TAP;
    cmd_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    cmd_wr = 1'b0;
    // A stale code must not look like a fresh commit
    command_register = ~CMD_CFG_TAP;
  endtask

  // Control bytes change together, away from any command
  task automatic set_ctrl(input logic [7:0] eng, input logic [7:0] sens, input logic [7:0] pins);
    @(posedge sys_clk);
    #1;
    engine_enable_reg = eng;
    sensor_enable_reg = sens;
    pin_config_reg = pins;
  endtask

  // Reading the status byte clears its tap flag
  task automatic read_status();
    @(posedge sys_clk);
    #1;
    event_status_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    event_status_rd = 1'b0;
  endtask
endmodule

// ===== dv/tde_tap_engine_bench.sv
// Purpose: Self-checking bench for the tap detection engine.
// Assumes: Acceleration weight 0 freezes the average, so linear values equal samples.
// Notes: Sample rate is scaled down to one strobe every six clocks.
`timescale 1ns/1ps
module tde_tap_engine_bench;
  import tde_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sample_ready = 1'b0;
  logic signed [SAMPLE_W-1:0] accel_x = '0;
  logic signed [SAMPLE_W-1:0] accel_y = '0;
  logic signed [SAMPLE_W-1:0] accel_z = '0;
  logic [BYTE_W-1:0] param_byte1_low, param_byte1_high, param_byte2_low, param_byte2_high;
  logic [BYTE_W-1:0] param_byte3_low, param_byte3_high, param_set_selector, command_register;
  logic [BYTE_W-1:0] engine_enable_reg, sensor_enable_reg, pin_config_reg;
  logic [BYTE_W-1:0] tap_result, event_status_reg;
  logic cmd_wr, event_status_rd, irq_pin_a, irq_pin_b;
  logic hit_a = 1'b0;
  logic hit_b = 1'b0;
  int err_total = 0;
  int compares = 0;
  int seed = 32'h97bbf803;
  // Tie order for each priority code, first entry wins
  localparam logic [5:0] ORD [8] = '{{AX_X, AX_Y, AX_Z}, {AX_X, AX_Z, AX_Y},
    {AX_Y, AX_X, AX_Z}, {AX_Y, AX_Z, AX_X}, {AX_Z, AX_X, AX_Y}, {AX_Z, AX_Y, AX_X},
    {AX_X, AX_Y, AX_Z}, {AX_X, AX_Y, AX_Z}};

  tde_host_model u_host (.sys_clk, .param_byte1_low, .param_byte1_high, .param_byte2_low,
    .param_byte2_high, .param_byte3_low, .param_byte3_high, .param_set_selector, .cmd_wr,
    .command_register, .engine_enable_reg, .sensor_enable_reg, .pin_config_reg,
    .event_status_rd);

  tde_tap_engine u_dut (.sys_clk, .rst_n, .param_byte1_low, .param_byte1_high,
    .param_byte2_low, .param_byte2_high, .param_byte3_low, .param_byte3_high,
    .param_set_selector, .cmd_wr, .command_register, .engine_enable_reg,
    .sensor_enable_reg, .pin_config_reg, .event_status_rd, .sample_ready, .accel_x,
    .accel_y, .accel_z, .tap_result, .event_status_reg, .irq_pin_a, .irq_pin_b);

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // Latch pin activity, since a pin only stands for one sample period
  always @(posedge sys_clk)
  begin
    if (irq_pin_a === 1'b1)
      hit_a <= 1'b1;
    if (irq_pin_b === 1'b1)
      hit_b <= 1'b1;
  end

  // Hang guard: a bounded run, exhausting it is a failure
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    err_total++;
    finish_test();
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Winning axis among the equal-magnitude axes in on (bit0 X, bit1 Y, bit2 Z)
  function automatic logic [1:0] exp_axis(input logic [2:0] p, input logic [2:0] on);
    logic [1:0] a;
    for (int i = 2; i >= 0; i--)
    begin
      a = ORD[p][2*i +: 2];
      if (on[a-1])
        return a;
    end
    return 2'h0;
  endfunction

  // One strobed sample; data lines scramble once the strobe is gone
  task automatic put(input int x, input int y, input int z);
    @(posedge sys_clk);
    #1;
    sample_ready = 1'b1;
    accel_x = 16'(x);
    accel_y = 16'(y);
    accel_z = 16'(z);
    @(posedge sys_clk);
    #1;
    sample_ready = 1'b0;
    accel_x = ~accel_x;
    accel_y = ~accel_y;
    accel_z = ~accel_z;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // Peak, quiet gap, optional second peak (early lands inside the quiet span), long tail
  task automatic shape(input logic [2:0] on, input int mag, input logic neg, input bit dbl,
    input bit early);
    int v;
    v = neg ? -mag : mag;
    put(on[0] ? v : 0, on[1] ? v : 0, on[2] ? v : 0);
    repeat (early ? 3 : 7) put(0, 0, 0);
    if (dbl || early)
      put(on[0] ? v : 0, on[1] ? v : 0, on[2] ? v : 0);
    repeat (16) put(0, 0, 0);
  endtask

  // Main sequence
  initial
  begin
    logic [2:0] on;
    logic [1:0] axis;
    logic [1:0] cnt;
    logic neg;
    int mag;
    logic [7:0] last;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    check(tap_result, 8'h00);
    check(event_status_reg, 8'h00);
    check({irq_pin_a, irq_pin_b}, 2'b00);
    // Weights 0 and 1.0, peak 0x0320, quiet 0x0190
    u_host.commit(SEL_SET2, 48'h0190_0320_8000);
    // A selector nibble of 3 must be ignored, or no tap would cross the threshold
    u_host.commit(4'h3, 48'hffff_ffff_ffff);
    // Every priority code, random tie sets, polarity and level, both counts
    for (int p = 0; p < 8; p++)
    begin
      on = 3'(({$random(seed)} % 7) + 1);
      mag = 1000 + ({$random(seed)} % 3000);
      neg = 1'($random(seed));
      cnt = (p[1] ^ p[2]) ? COUNT_DOUBLE : COUNT_SINGLE;
      axis = exp_axis(3'(p), on);
      u_host.commit(SEL_SET1, {16'h0014, 16'h0003, 5'($random(seed)), 3'(p), 8'h03});
      u_host.set_ctrl({1'b0, p[0], 6'h01}, 8'h01, (p == 7) ? 8'h00 : 8'h18);
      hit_a = 1'b0;
      hit_b = 1'b0;
      shape(on, mag, neg, cnt == COUNT_DOUBLE, 1'b0);
      last = {neg, 1'b0, axis, 2'b00, cnt};
      check(tap_result, last);
      check(event_status_reg, 8'h02);
      check({hit_a, hit_b}, (p == 7) ? 2'b00 : {p[0], ~p[0]});
      u_host.read_status();
      check(event_status_reg, 8'h00);
    end
    // Second peak inside the quiet span, then engine off, then accel off
    for (int k = 0; k < 3; k++)
    begin
      u_host.set_ctrl((k == 1) ? 8'h40 : 8'h41, (k == 2) ? 8'h00 : 8'h01, 8'h18);
      hit_a = 1'b0;
      hit_b = 1'b0;
      shape(3'b001, 2000, 1'b0, 1'b0, k == 0);
      check(event_status_reg, 8'h00);
      check({hit_a, hit_b}, 2'b00);
      check(tap_result, last);
    end
    finish_test();
  end
endmodule
